// *** logic/iefu_pkg.sv ***
// Package: register map, bit positions and reset values of the interrupt enable and flag unit
package iefu_pkg;
  // Register byte addresses on the APB
  localparam logic [7:0] IEFU_ADDR_INTCTL = 8'h00;
  localparam logic [7:0] IEFU_ADDR_PEN1 = 8'h04;
  localparam logic [7:0] IEFU_ADDR_PEN2 = 8'h08;
  localparam logic [7:0] IEFU_ADDR_PREQ1 = 8'h0C;
  localparam logic [7:0] IEFU_ADDR_PREQ2 = 8'h10;
  localparam logic [7:0] IEFU_ADDR_OPTION = 8'h14;
  localparam logic [7:0] IEFU_ADDR_PINMASK = 8'h18;
  localparam logic [7:0] IEFU_ADDR_CORE = 8'h1C;
  // Interrupt control bit positions
  localparam int IEFU_GIE_BIT = 7;
  localparam int IEFU_PGE_BIT = 6;
  localparam int IEFU_T0E_BIT = 5;
  localparam int IEFU_EXE_BIT = 4;
  localparam int IEFU_PCE_BIT = 3;
  localparam int IEFU_T0F_BIT = 2;
  localparam int IEFU_EXF_BIT = 1;
  localparam int IEFU_PCF_BIT = 0;
  // Peripheral request one bit positions
  localparam int IEFU_GATE_BIT = 7;
  localparam int IEFU_ADC_BIT = 6;
  localparam int IEFU_RX_BIT = 5;
  localparam int IEFU_TX_BIT = 4;
  localparam int IEFU_SSP_BIT = 3;
  localparam int IEFU_CC1_BIT = 2;
  localparam int IEFU_TM2_BIT = 1;
  localparam int IEFU_TM1_BIT = 0;
  // Option register edge select
  localparam int IEFU_EDGE_BIT = 6;
  // Reset values
  localparam logic [7:0] IEFU_INTCTL_RST = 8'h00;
  localparam logic [7:0] IEFU_PEN_RST = 8'h00;
  localparam logic [7:0] IEFU_PREQ_RST = 8'h00;
  localparam logic [7:0] IEFU_OPTION_RST = 8'hFF;
  localparam logic [7:0] IEFU_PINMASK_RST = 8'h00;
  // Vector address and latency
  localparam logic [12:0] IEFU_VECTOR = 13'h0004;
  localparam int IEFU_LATENCY_CYC = 3;
  // Capture/compare modes
  typedef enum logic [1:0] {
    IEFU_CC_CAPTURE = 2'b00,
    IEFU_CC_COMPARE = 2'b01,
    IEFU_CC_PWM = 2'b10
  } iefu_ccmode_e;
endpackage : iefu_pkg

// *** logic/iefu_top.sv ***
// Interrupt enable and flag unit: enables, flags, request and vector sequence
`timescale 1ns/100ps
//
// Function
// RULE1 - Global enable bit 7 gates all requests
// RULE2 - Peripheral group enable bit 6 gates peripherals
// RULE3 - Timer zero rollover sets flag, enable masks
// RULE4 - External pin event sets sticky flag
// RULE5 - Port change counts only mask-enabled pins
// RULE6 - Port change flag set on change, sticky
// RULE7 - Flags set regardless of any enable
// RULE8 - Software clears flag before enabling it
// RULE9 - Enable one holds eight peripheral enables
// RULE10 - Enable two has only bit 0
// RULE11 - Gate flag reads one while gate inactive
// RULE12 - Conversion flag set on completion, sticky
// RULE13 - Receive flag follows full buffer, read-clears
// RULE14 - Transmit flag follows empty buffer, write-clears
// RULE15 - Sync port flag set on completion, sticky
// RULE16 - Capcmp one flag by mode, unused PWM
// RULE17 - Timer two period match flag, sticky
// RULE18 - Timer one overflow flag, sticky
// RULE19 - Request two has only capcmp two flag
// RULE20 - Software initialises timer zero before clearing
// RULE21 - Vectoring clears global enable, loads 0004h
// RULE22 - Return from interrupt sets global enable
// RULE23 - Vector reached three cycles after event
// RULE24 - Edge select picks rising or falling edge
// RULE25 - Request combines core and peripheral pairs
module iefu_top
  import iefu_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pins
  input wire logic external_irq_pin_i,
  input wire logic [7:0] port_pins_i,
  // Peripheral events, same clock
  input wire logic timer_zero_ovf_i,
  input wire logic timer_one_gate_active_i,
  input wire logic conversion_done_i,
  input wire logic serial_rx_full_i,
  input wire logic serial_tx_empty_i,
  input wire logic sync_port_done_i,
  input wire logic [1:0] capcmp_one_mode_i,
  input wire logic capcmp_one_capture_i,
  input wire logic capcmp_one_match_i,
  input wire logic [1:0] capcmp_two_mode_i,
  input wire logic capcmp_two_capture_i,
  input wire logic capcmp_two_match_i,
  input wire logic timer_two_match_i,
  input wire logic timer_one_ovf_i,
  // Serial data register accesses
  input wire logic serial_rx_data_read_i,
  input wire logic serial_tx_data_write_i,
  // Core side
  input wire logic return_from_irq_i,
  output logic irq_request_o,
  output logic flush_prefetch_o,
  output logic push_pc_o,
  output logic load_vector_o,
  output logic [12:0] vector_addr_o,
  output logic serial_rx_clear_o,
  output logic serial_tx_clear_o
);

  typedef enum logic [1:0] {
    IEFU_IDLE = 2'b00,
    IEFU_FLUSH = 2'b01,
    IEFU_PUSH = 2'b10,
    IEFU_LOAD = 2'b11
  } iefu_state_e;

  // Software visible registers
  logic [7:0] intctl_r;
  logic [7:0] pen1_r;
  logic pen2_r;
  logic [7:0] preq1_r;
  logic preq2_r;
  logic [7:0] option_r;
  logic [7:0] pinmask_r;
  // External pin synchroniser and previous sample
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_d_r;
  // Port pin synchronisers and previous sample
  logic [7:0] port_s1_r;
  logic [7:0] port_s2_r;
  logic [7:0] port_d_r;
  // Fill marker: edge detection waits for real samples after reset
  logic [2:0] sync_fill_r;
  logic sync_ok;
  // Vector sequencer
  iefu_state_e state_r;
  iefu_state_e state_nxt;

  // Bus strobes
  logic acc;
  logic wr;
  // Detected events and request
  logic ext_edge;
  logic port_change;
  logic pend;
  logic vector_take;
  logic cc1_evt;
  logic cc2_evt;
  // Peripheral request one next value and read data
  logic [7:0] flags1_set;
  logic [7:0] flags1_wr;
  logic [7:0] rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode: zero wait states, every access taken at its access phase
  // The access phase lasts one cycle, so pready need not qualify it
  assign acc = psel_i & penable_i & clk_en_i;
  assign wr = acc & pwrite_i;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
      port_s1_r <= 8'h00;
      port_s2_r <= 8'h00;
      port_d_r <= 8'h00;
    end else if (clk_en_i) begin
      ext_s1_r <= external_irq_pin_i;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
      port_s1_r <= port_pins_i;
      port_s2_r <= port_s1_r;
      port_d_r <= port_s2_r;
    end
  end

  // Fill marker: ones shift in after reset, one per enabled edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_fill_r <= 3'h0;
    end else if (clk_en_i) begin
      sync_fill_r <= {sync_fill_r[1:0], 1'h1};
    end
  end

  // Both samples real after three edges; a pin held through reset is no edge
  assign sync_ok = sync_fill_r[2];

  // Edge polarity from option register
  assign ext_edge = sync_ok &
      (option_r[IEFU_EDGE_BIT] ? (ext_s2_r & ~ext_d_r) : (~ext_s2_r & ext_d_r)); // RULE24
  assign port_change = sync_ok & (|((port_s2_r ^ port_d_r) & pinmask_r)); // RULE5

  // Capture/compare events by mode, nothing in PWM
  assign cc1_evt = (capcmp_one_mode_i == IEFU_CC_CAPTURE) ? capcmp_one_capture_i :
                   (capcmp_one_mode_i == IEFU_CC_COMPARE) ? capcmp_one_match_i : 1'b0; // RULE16
  assign cc2_evt = (capcmp_two_mode_i == IEFU_CC_CAPTURE) ? capcmp_two_capture_i :
                   (capcmp_two_mode_i == IEFU_CC_COMPARE) ? capcmp_two_match_i : 1'b0; // RULE19

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt control register; flags set regardless of enables, set beats clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      intctl_r <= IEFU_INTCTL_RST;
    end else if (clk_en_i) begin
      if (wr && paddr_i == IEFU_ADDR_INTCTL) begin
        intctl_r <= pwdata_i[7:0];
      end
      // Vector take wins over a return in the same cycle
      if (vector_take) begin
        intctl_r[IEFU_GIE_BIT] <= 1'b0; // RULE21
      end else if (return_from_irq_i) begin
        intctl_r[IEFU_GIE_BIT] <= 1'b1; // RULE22
      end
      // Hardware sets come last, so they beat a software clear
      if (timer_zero_ovf_i) begin
        intctl_r[IEFU_T0F_BIT] <= 1'b1; // RULE3 RULE7
      end
      if (ext_edge) begin
        intctl_r[IEFU_EXF_BIT] <= 1'b1; // RULE4 RULE7
      end
      if (port_change) begin
        intctl_r[IEFU_PCF_BIT] <= 1'b1; // RULE6 RULE7
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable, option and pin mask registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pen1_r <= IEFU_PEN_RST;
      pen2_r <= 1'b0;
      option_r <= IEFU_OPTION_RST;
      pinmask_r <= IEFU_PINMASK_RST;
    end else if (clk_en_i && wr) begin
      if (paddr_i == IEFU_ADDR_PEN1) begin
        pen1_r <= pwdata_i[7:0]; // RULE9
      end
      if (paddr_i == IEFU_ADDR_PEN2) begin
        pen2_r <= pwdata_i[0]; // RULE10
      end
      if (paddr_i == IEFU_ADDR_OPTION) begin
        option_r <= pwdata_i[7:0];
      end
      if (paddr_i == IEFU_ADDR_PINMASK) begin
        pinmask_r <= pwdata_i[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Peripheral request registers
  // Event sets for request one; the live bits take none here
  assign flags1_set = {1'b0, conversion_done_i, 2'b00, sync_port_done_i, cc1_evt,
                       timer_two_match_i, timer_one_ovf_i};
  assign flags1_wr = (wr && paddr_i == IEFU_ADDR_PREQ1) ? pwdata_i[7:0] : preq1_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      preq1_r <= IEFU_PREQ_RST;
      preq2_r <= 1'b0;
    end else if (clk_en_i) begin
      preq1_r <= flags1_wr | flags1_set; // RULE12 RULE15 RULE16 RULE17 RULE18
      // Live bits follow their inputs, writes to them are ignored
      preq1_r[IEFU_GATE_BIT] <= ~timer_one_gate_active_i; // RULE11
      preq1_r[IEFU_RX_BIT] <= serial_rx_full_i; // RULE13
      preq1_r[IEFU_TX_BIT] <= serial_tx_empty_i; // RULE14
      if (cc2_evt) begin
        preq2_r <= 1'b1; // RULE19
      end else if (wr && paddr_i == IEFU_ADDR_PREQ2) begin
        preq2_r <= pwdata_i[0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Combined pending request
  // Core pairs under the global enable, peripheral pairs also under the group enable
  assign pend = intctl_r[IEFU_GIE_BIT] & (
      (intctl_r[IEFU_T0E_BIT] & intctl_r[IEFU_T0F_BIT]) |
      (intctl_r[IEFU_EXE_BIT] & intctl_r[IEFU_EXF_BIT]) |
      (intctl_r[IEFU_PCE_BIT] & intctl_r[IEFU_PCF_BIT]) |
      (intctl_r[IEFU_PGE_BIT] & ((|(pen1_r & preq1_r)) | (pen2_r & preq2_r)))); // RULE1 RULE2 RULE25
  assign vector_take = (state_r == IEFU_IDLE) & pend;

  //////////////////////////////////////////////////////////////////////////////
  // Vector sequence: flush, push, load over three cycles
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // Leave idle only for an enabled request
      IEFU_IDLE: begin
        if (pend) begin
          state_nxt = IEFU_FLUSH; // RULE23
        end
      end
      // One cycle per step, no restart before idle
      IEFU_FLUSH: begin
        state_nxt = IEFU_PUSH;
      end
      IEFU_PUSH: begin
        state_nxt = IEFU_LOAD;
      end
      IEFU_LOAD: begin
        state_nxt = IEFU_IDLE;
      end
      default: begin
        state_nxt = IEFU_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= IEFU_IDLE;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
    end
  end

  // Core strobes, registered
  // Strobes follow the next state, so each leaves its flop in step with the state
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_request_o <= 1'b0;
      flush_prefetch_o <= 1'b0;
      push_pc_o <= 1'b0;
      load_vector_o <= 1'b0;
      vector_addr_o <= IEFU_VECTOR;
      serial_rx_clear_o <= 1'b0;
      serial_tx_clear_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_request_o <= pend; // RULE25
      flush_prefetch_o <= (state_nxt == IEFU_FLUSH); // RULE21
      push_pc_o <= (state_nxt == IEFU_PUSH);
      load_vector_o <= (state_nxt == IEFU_LOAD);
      vector_addr_o <= IEFU_VECTOR;
      serial_rx_clear_o <= serial_rx_data_read_i; // RULE13
      serial_tx_clear_o <= serial_tx_data_write_i; // RULE14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  // Unmapped and misaligned addresses read zero
  always_comb begin
    case (paddr_i)
      IEFU_ADDR_INTCTL: rdata = intctl_r;
      IEFU_ADDR_PEN1: rdata = pen1_r;
      IEFU_ADDR_PEN2: rdata = {7'h00, pen2_r};
      IEFU_ADDR_PREQ1: rdata = preq1_r;
      IEFU_ADDR_PREQ2: rdata = {7'h00, preq2_r};
      IEFU_ADDR_OPTION: rdata = option_r;
      IEFU_ADDR_PINMASK: rdata = pinmask_r;
      IEFU_ADDR_CORE: rdata = {6'h00, state_r};
      default: rdata = 8'h00;
    endcase
  end

  // APB answer registered one cycle after setup
  // Error flags addresses past the map or off a word boundary
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o <= psel_i & ~penable_i;
      prdata_o <= {24'h00_0000, rdata};
      pslverr_o <= psel_i & ~penable_i & (paddr_i > IEFU_ADDR_CORE || paddr_i[1:0] != 2'b00);
    end
  end

endmodule : iefu_top

// *** testbench/iefu_core_model.sv ***
// Partner model: peripheral event pulses and core return from interrupt
`timescale 1ns/100ps
module iefu_core_model #(
  parameter int RET_DLY = 40
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Bench requests and vector strobe
  input wire logic [7:0] fire_i,
  input wire logic load_vector_i,
  // Event pulses and return
  output logic [7:0] ev_o,
  output logic ret_o
);
  int cnt_r;
  // One-cycle event pulses
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ev_o <= 8'h00;
    else ev_o <= fire_i;
  end
  // Handler time, then return
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 0;
      ret_o <= 1'h0;
    end else begin
      ret_o <= (cnt_r == 1);
      if (load_vector_i) cnt_r <= RET_DLY;
      else if (cnt_r != 0) cnt_r <= cnt_r - 1;
    end
  end
endmodule : iefu_core_model

// *** testbench/iefu_checker.sv ***
// Checker: bus answer timing, vector sequence, serial clear echo
`timescale 1ns/100ps
module iefu_checker (
  // Clock, reset, bus
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Serial and core side
  input wire logic serial_rx_data_read_i,
  input wire logic serial_tx_data_write_i,
  input wire logic serial_rx_clear_o,
  input wire logic serial_tx_clear_o,
  input wire logic irq_request_o,
  input wire logic flush_prefetch_o,
  input wire logic push_pc_o,
  input wire logic load_vector_o,
  input wire logic [12:0] vector_addr_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_setup;
    psel_i && !penable_i && clk_en_i;
  endsequence
  sequence s_vector;
    flush_prefetch_o ##1 push_pc_o ##1 load_vector_o;
  endsequence
  a_ready_next: assert property (s_setup |=> pready_o) else $error("no ready after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  a_bad_addr: assert property (psel_i && !penable_i && clk_en_i && (paddr_i > 8'h1C || paddr_i[1:0] != 2'h0)
    |=> pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper read bits set");
  a_vec_order: assert property ($rose(flush_prefetch_o) |-> s_vector) else $error("vector steps out of order");
  a_vec_addr: assert property (load_vector_o |-> vector_addr_o == 13'h0004) else $error("wrong vector");
  a_flush_cause: assert property (flush_prefetch_o |-> irq_request_o) else $error("flush without request");
  a_no_revector: assert property (flush_prefetch_o |=> !flush_prefetch_o [*2]) else $error("vector retaken");
  a_rx_clear: assert property (serial_rx_data_read_i && clk_en_i |=> serial_rx_clear_o) else $error("rx clear");
  a_tx_clear: assert property (serial_tx_data_write_i && clk_en_i |=> serial_tx_clear_o) else $error("tx clear");
endmodule : iefu_checker
bind iefu_top iefu_checker i_iefu_checker (.*);

// *** testbench/iefu_top_tb.sv ***
// Testbench: register access, flag setting, masking and vector sequence
`timescale 1ns/100ps
module iefu_top_tb;
  import iefu_pkg::*;
  logic sys_clk_i = 1'h0, rst_n_i = 1'h0, clk_en_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic external_irq_pin_i = 1'h0, timer_one_gate_active_i = 1'h1, serial_rx_full_i = 1'h0, serial_tx_empty_i = 1'h0;
  logic serial_rx_data_read_i = 1'h0, serial_tx_data_write_i = 1'h0, ret;
  logic [1:0] capcmp_one_mode_i = 2'h0, capcmp_two_mode_i = 2'h0;
  logic [7:0] paddr_i = 8'h00, port_pins_i = 8'h00, fire = 8'h00, ev, r;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic [12:0] vector_addr_o;
  logic pready_o, pslverr_o, irq_request_o, flush_prefetch_o, push_pc_o, load_vector_o;
  logic serial_rx_clear_o, serial_tx_clear_o;
  logic [15:0] exp_q[$];
  int n_errors = 0, checked = 0, i;
  iefu_top i_iefu_top (.*, .timer_zero_ovf_i(ev[0]), .conversion_done_i(ev[1]), .sync_port_done_i(ev[2]),
    .capcmp_one_capture_i(ev[3]), .timer_two_match_i(ev[4]), .timer_one_ovf_i(ev[5]),
    .capcmp_two_capture_i(ev[6]), .capcmp_one_match_i(ev[7]), .capcmp_two_match_i(ev[7]), .return_from_irq_i(ret));
  iefu_core_model i_iefu_core_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .load_vector_i(load_vector_o), .ev_o(ev), .ret_o(ret));
  always #2 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // One APB transfer; reads leave their expectation in the queue
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk_i);
    if (!wr) exp_q.push_back({a, d});
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (pready_o !== 1'h1 && k < 20);
    if (pready_o !== 1'h1) begin
      $display("ERROR apb ready expected 1 seen %b", pready_o);
      n_errors++;
      end_sim();
    end
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask : apb
  task automatic pulse(input logic [7:0] f);
    @(posedge sys_clk_i);
    fire <= f;
    @(posedge sys_clk_i);
    fire <= 8'h00;
    repeat (3) @(posedge sys_clk_i);
  endtask : pulse
  task automatic wait_vec();
    for (i = 0; i < 12 && flush_prefetch_o !== 1'h1; i++) @(posedge sys_clk_i);
    chk("vector taken", 8'h01, {7'h0, flush_prefetch_o});
    if (i == 12) end_sim();
  endtask : wait_vec
  // Read data against the oldest expectation
  always @(posedge sys_clk_i) begin
    if (psel_i && penable_i && pready_o === 1'h1 && !pwrite_i && exp_q.size() > 0) begin
      chk($sformatf("read %h", exp_q[0][15:8]), exp_q[0][7:0], prdata_o[7:0]);
      void'(exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(51654));
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    for (i = 0; i < 7; i++) apb(1'h0, 8'(i * 4), (i == 5) ? 8'hFF : 8'h00);
    apb(1'h0, 8'h20, 8'h00);
    $display("test reset values done");
    r = 8'($urandom);
    apb(1'h1, 8'h04, r);
    apb(1'h0, 8'h04, r);
    apb(1'h1, 8'h08, 8'hFF);
    apb(1'h0, 8'h08, 8'h01);
    apb(1'h1, 8'h04, 8'h00);
    apb(1'h1, 8'h08, 8'h00);
    $display("test enables done");
    pulse(8'h7F);
    apb(1'h0, 8'h00, 8'h04);
    apb(1'h0, 8'h0C, 8'h4F);
    apb(1'h0, 8'h10, 8'h01);
    apb(1'h1, 8'h0C, 8'h00);
    apb(1'h1, 8'h10, 8'h00);
    apb(1'h1, 8'h00, 8'h00);
    apb(1'h0, 8'h0C, 8'h00);
    capcmp_one_mode_i <= IEFU_CC_COMPARE;
    capcmp_two_mode_i <= IEFU_CC_COMPARE;
    pulse(8'h80);
    apb(1'h0, 8'h0C, 8'h04);
    apb(1'h0, 8'h10, 8'h01);
    apb(1'h1, 8'h0C, 8'h00);
    apb(1'h1, 8'h10, 8'h00);
    capcmp_one_mode_i <= IEFU_CC_PWM;
    capcmp_two_mode_i <= IEFU_CC_PWM;
    pulse(8'hC8);
    apb(1'h0, 8'h0C, 8'h00);
    apb(1'h0, 8'h10, 8'h00);
    clk_en_i <= 1'h0;
    pulse(8'h02);
    clk_en_i <= 1'h1;
    apb(1'h0, 8'h0C, 8'h00);
    $display("test flags done");
    timer_one_gate_active_i <= 1'h0;
    serial_rx_full_i <= 1'h1;
    serial_tx_empty_i <= 1'h1;
    apb(1'h1, 8'h0C, 8'h00);
    apb(1'h0, 8'h0C, 8'hB0);
    serial_rx_data_read_i <= 1'h1;
    serial_tx_data_write_i <= 1'h1;
    @(posedge sys_clk_i);
    serial_rx_data_read_i <= 1'h0;
    serial_tx_data_write_i <= 1'h0;
    serial_rx_full_i <= 1'h0;
    serial_tx_empty_i <= 1'h0;
    timer_one_gate_active_i <= 1'h1;
    apb(1'h0, 8'h0C, 8'h00);
    $display("test live flags done");
    for (i = 0; i < 2; i++) begin
      apb(1'h1, 8'h14, i ? 8'hBF : 8'hFF);
      external_irq_pin_i <= !i;
      repeat (5) @(posedge sys_clk_i);
      apb(1'h0, 8'h00, 8'h02);
      apb(1'h1, 8'h00, 8'h00);
    end
    apb(1'h1, 8'h18, 8'h01);
    for (i = 1; i >= 0; i--) begin
      port_pins_i <= port_pins_i ^ (8'h01 << i);
      repeat (5) @(posedge sys_clk_i);
      apb(1'h0, 8'h00, i ? 8'h00 : 8'h01);
    end
    apb(1'h1, 8'h00, 8'h00);
    $display("test pins done");
    pulse(8'h01);
    apb(1'h1, 8'h00, 8'h24);
    repeat (3) @(posedge sys_clk_i);
    chk("irq request", 8'h00, {7'h0, irq_request_o});
    apb(1'h1, 8'h00, 8'hA4);
    wait_vec();
    apb(1'h0, 8'h00, 8'h24);
    apb(1'h1, 8'h00, 8'h20);
    for (i = 0; i < 60 && ret !== 1'h1; i++) @(posedge sys_clk_i);
    chk("core return", 8'h01, {7'h0, ret});
    if (i == 60) end_sim();
    repeat (3) @(posedge sys_clk_i);
    apb(1'h0, 8'h00, 8'hA0);
    pulse(8'h20);
    apb(1'h1, 8'h04, 8'h01);
    repeat (3) @(posedge sys_clk_i);
    chk("irq request", 8'h00, {7'h0, irq_request_o});
    apb(1'h1, 8'h00, 8'hC0);
    wait_vec();
    $display("test vector done");
    repeat (4) @(posedge sys_clk_i);
    external_irq_pin_i <= 1'h1;
    rst_n_i <= 1'h0;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    repeat (5) @(posedge sys_clk_i);
    apb(1'h0, 8'h00, 8'h00);
    apb(1'h0, 8'h04, 8'h00);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : iefu_top_tb
